// ==== design/ppc_power_control.sv ====
`timescale 1ns/100ps
// What this block does
// RULE_01: Register reads at 3Dh to 3Fh; write at 3Dh, set 3Eh, clear 3Fh.
// RULE_02: Link never writes ones to reserved bits 7 to 5 and 1 to 0.
// RULE_03: Bit 4 set enables weak pull-up only while A-session-valid is high.
// RULE_04: UART mode forces the weak pull-up on regardless of bit 4.
// RULE_05: Bit 3 set: B-session-valid fall sends receive command with alternate flag.
// RULE_06: Bit 2 set: B-session-valid rise sends receive command with alternate flag.
// RULE_07: Register resets to all zeros; pull-up and edge reports off.
// RULE_08: Link enters UART mode via carkit bit then routing enables.
// RULE_09: Set address ORs written ones in; clear address clears written ones.
module ppc_power_control (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ppc_pkg::ppc_req_s req,
  input wire ppc_pkg::ppc_stat_s stat_pin,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic dplus_weak_pullup_enable,
  output logic rxcmd_request,
  output logic alternate_interrupt_flag
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  ppc_pkg::ppc_stat_s stat_meta;
  ppc_pkg::ppc_stat_s stat_sync;
  logic b_valid_prev;

  // Comparator outputs are asynchronous to the interface clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_meta <= '0;
      stat_sync <= '0;
      b_valid_prev <= 1'b0;
    end else begin
      stat_meta <= stat_pin;
      stat_sync <= stat_meta;
      b_valid_prev <= stat_sync.b_session_valid;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] power_control;
  logic [7:0] next_power_control;
  logic [7:0] next_rdata;
  logic next_rdata_valid;

  // True for any of the three aliases of the register
  function automatic logic hits_reg(input logic [5:0] a);
    hits_reg = (a == ppc_pkg::ADDR_WRITE) || (a == ppc_pkg::ADDR_SET) || (a == ppc_pkg::ADDR_CLEAR);
  endfunction : hits_reg

  // Write, set and clear; reserved bits stored as written, link keeps them zero
  always_comb begin
    next_power_control = power_control;
    next_rdata = rdata;
    next_rdata_valid = 1'b0;
    if (req.wr) begin
      case (req.addr)
        ppc_pkg::ADDR_WRITE: next_power_control = req.wdata; // [RULE_01] [RULE_02]
        ppc_pkg::ADDR_SET: next_power_control = power_control | req.wdata; // [RULE_09]
        ppc_pkg::ADDR_CLEAR: next_power_control = power_control & ~req.wdata; // [RULE_09]
        default: next_power_control = power_control;
      endcase
    end
    if (req.rd) begin
      next_rdata_valid = 1'b1;
      // Unmapped reads answer zero so the link never sees stale data
      next_rdata = hits_reg(req.addr) ? power_control : 8'h00; // [RULE_01]
    end
  end

  // Register byte and read answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_control <= ppc_pkg::POWER_CONTROL_RESET; // [RULE_07]
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      power_control <= next_power_control;
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
    end
  end

  // ****************************************
  // Register file checks
  // ****************************************
  // Reset clears the register and every output
  a_reset_state: assert property (@(posedge clk) // [RULE_07]
    sys_rst
    |=> power_control == ppc_pkg::POWER_CONTROL_RESET && rdata == 8'h00 && !rdata_valid
      && !dplus_weak_pullup_enable && !rxcmd_request && !alternate_interrupt_flag)
    else $error("Outputs not cleared by reset");
  // First edge after release still shows the reset value
  a_reset_zero: assert property (@(posedge clk) // [RULE_07]
    $fell(sys_rst)
    |-> power_control == ppc_pkg::POWER_CONTROL_RESET)
    else $error("Register not zero after reset");
  // Plain write replaces the whole byte
  a_write_load: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    req.wr && req.addr == ppc_pkg::ADDR_WRITE
    |=> power_control == $past(req.wdata))
    else $error("Write access wrong");
  // Set alias ORs the written ones in
  a_set_or: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
    req.wr && req.addr == ppc_pkg::ADDR_SET
    |=> power_control == ($past(power_control) | $past(req.wdata)))
    else $error("Set access wrong");
  // Clear alias drops only the written ones
  a_clear_and: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
    req.wr && req.addr == ppc_pkg::ADDR_CLEAR
    |=> power_control == ($past(power_control) & ~$past(req.wdata)))
    else $error("Clear access wrong");
  // Without a write the byte never moves
  a_hold_idle: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
    !req.wr
    |=> power_control == $past(power_control))
    else $error("Register changed without write");
  // Writes to foreign addresses are ignored
  a_foreign_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    req.wr && !hits_reg(req.addr)
    |=> power_control == $past(power_control))
    else $error("Foreign write changed register");
  // Every alias returns the current byte
  a_read_alias: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    req.rd && hits_reg(req.addr) && !req.wr
    |=> rdata_valid
      && rdata == power_control)
    else $error("Read alias wrong");
  // A read beside a write returns the old byte
  a_read_old: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    req.rd && req.wr && hits_reg(req.addr)
    |=> rdata_valid && rdata == $past(power_control))
    else $error("Read beside write not old value");
  // Foreign reads answer zero
  a_foreign_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    req.rd && !hits_reg(req.addr)
    |=> rdata_valid && rdata == 8'h00)
    else $error("Foreign read not zero");
  // Valid only ever follows a read strobe
  a_valid_pulse: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    rdata_valid
    |-> $past(req.rd))
    else $error("Read valid without read");
  // Valid stands one cycle only
  a_valid_idle: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    !req.rd
    |=> !rdata_valid)
    else $error("Read valid without strobe");
  // Read data stands until the next read
  a_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
    !req.rd
    |=> rdata == $past(rdata))
    else $error("Read data changed without read");

  // ****************************************
  // Pull-up and edge reports
  // ****************************************
  logic next_pullup;
  logic next_rxcmd;
  logic rise_seen;
  logic fall_seen;

  // Edge detect works on the second synchroniser stage only
  always_comb begin
    rise_seen = stat_sync.b_session_valid && !b_valid_prev;
    fall_seen = !stat_sync.b_session_valid && b_valid_prev;
    next_pullup = stat_sync.uart_mode // [RULE_04]
      || (power_control[ppc_pkg::BIT_PULLUP] && stat_sync.a_session_valid); // [RULE_03]
    next_rxcmd = (power_control[ppc_pkg::BIT_FALL] && fall_seen) // [RULE_05]
      || (power_control[ppc_pkg::BIT_RISE] && rise_seen); // [RULE_06]
  end

  // Pull-up level and report pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dplus_weak_pullup_enable <= 1'b0;
      rxcmd_request <= 1'b0;
      alternate_interrupt_flag <= 1'b0;
    end else begin
      dplus_weak_pullup_enable <= next_pullup;
      rxcmd_request <= next_rxcmd;
      alternate_interrupt_flag <= next_rxcmd;
    end
  end

  // ****************************************
  // Pull-up and edge report checks
  // ****************************************
  // UART mode forces the pull-up on
  a_uart_pullup: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_04]
    stat_sync.uart_mode
    |=> dplus_weak_pullup_enable)
    else $error("Pull-up off in UART mode");
  // Enable bit and session level together turn it on
  a_pullup_on: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_03]
    power_control[ppc_pkg::BIT_PULLUP] && stat_sync.a_session_valid
    |=> dplus_weak_pullup_enable)
    else $error("Pull-up off although enabled");
  // No cause, no pull-up
  a_pullup_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_03]
    !stat_sync.uart_mode
      && !(power_control[ppc_pkg::BIT_PULLUP] && stat_sync.a_session_valid)
    |=> !dplus_weak_pullup_enable)
    else $error("Pull-up on without cause");
  // Enabled fall sends one flagged report
  a_fall_report: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_05]
    power_control[ppc_pkg::BIT_FALL] && fall_seen
    |=> rxcmd_request && alternate_interrupt_flag)
    else $error("Fall edge not reported");
  // Enabled rise sends one flagged report
  a_rise_report: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_06]
    power_control[ppc_pkg::BIT_RISE] && rise_seen
    |=> rxcmd_request && alternate_interrupt_flag)
    else $error("Rise edge not reported");
  // Masked or absent edges send nothing
  a_edge_refused: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_05] [RULE_06]
    !(power_control[ppc_pkg::BIT_FALL] && fall_seen)
      && !(power_control[ppc_pkg::BIT_RISE] && rise_seen)
    |=> !rxcmd_request && !alternate_interrupt_flag)
    else $error("Report sent for masked edge");

endmodule : ppc_power_control

// ==== design/ppc_pkg.sv ====
package ppc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0] ADDR_WRITE = 6'h3D;
  localparam logic [5:0] ADDR_SET = 6'h3E;
  localparam logic [5:0] ADDR_CLEAR = 6'h3F;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned BIT_PULLUP = 4;
  localparam int unsigned BIT_FALL = 3;
  localparam int unsigned BIT_RISE = 2;

  // Register access request from the link-facing register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ppc_req_s;

  // Analog status from the comparators and the mode logic
  typedef struct packed {
    logic a_session_valid;
    logic b_session_valid;
    logic uart_mode;
  } ppc_stat_s;

endpackage : ppc_pkg

// ==== dv/ppc_link_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Link side register master
// ****************************************
module ppc_link_model (
  input wire logic clk,
  output ppc_pkg::ppc_req_s req
);
  initial req = '0;
  // One-cycle strobe launched at the falling edge, dropped one cycle later
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & 8'h1C}; // Reserved bits kept 0
    @(negedge clk);
    req <= '0;
  endtask : wr
  // Read strobe; the answer is picked up by the caller
  task rd(input logic [5:0] a);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
  endtask : rd
endmodule : ppc_link_model

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
// ****************************************
// Bench
// ****************************************
module tb_top;
  logic clk = 0, sys_rst = 1, pu, rv, rx, alt;
  logic [7:0] rq;
  ppc_pkg::ppc_req_s req;
  ppc_pkg::ppc_stat_s st = '0;
  int errors = 0, compares = 0;
  always #2 clk = ~clk;
  ppc_link_model lm (.clk(clk), .req(req));
  ppc_power_control dut (.clk(clk), .sys_rst(sys_rst), .req(req), .stat_pin(st), .rdata(rq),
    .rdata_valid(rv), .dplus_weak_pullup_enable(pu), .rxcmd_request(rx), .alternate_interrupt_flag(alt));
  task chk(string s, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // Bounded wait for the read answer, checked while valid stands
  task rreg(logic [5:0] a, logic [7:0] e);
    int i;
    lm.rd(a);
    for (i = 0; i < 4 && rv !== 1'b1; i++) @(negedge clk);
    chk("rdata_valid", 8'h01, {7'h00, rv});
    chk("rdata", e, rq);
  endtask : rreg
  // Pull-up level after the synchroniser settles
  task pchk(logic e);
    repeat (4) @(negedge clk);
    chk("pullup", {7'h00, e}, {7'h00, pu});
  endtask : pchk
  // Count event pulses after one change of the session level
  task ev(logic v, int n);
    int k;
    k = 0;
    st.b_session_valid = v;
    repeat (8) @(negedge clk) if (rx === 1'b1) begin
      k++;
      chk("alt_flag", 8'h01, {7'h00, alt});
    end
    chk("events", n[7:0], k[7:0]);
  endtask : ev
  task t_regs;
    rreg(ppc_pkg::ADDR_WRITE, 8'h00);
    lm.wr(ppc_pkg::ADDR_WRITE, 8'h10);
    lm.wr(ppc_pkg::ADDR_SET, 8'h0C);
    rreg(ppc_pkg::ADDR_SET, 8'h1C);
    lm.wr(ppc_pkg::ADDR_CLEAR, 8'h14);
    rreg(ppc_pkg::ADDR_CLEAR, 8'h08);
    lm.wr(6'h3C, 8'h10);
    rreg(6'h3C, 8'h00);
    rreg(ppc_pkg::ADDR_WRITE, 8'h08);
    $display("test regs done");
  endtask : t_regs
  task t_pullup;
    lm.wr(ppc_pkg::ADDR_WRITE, 8'h10);
    pchk(1'b0);
    st.a_session_valid = 1'b1;
    pchk(1'b1);
    lm.wr(ppc_pkg::ADDR_CLEAR, 8'h10);
    pchk(1'b0);
    st.uart_mode = 1'b1; // Mode level stands for the entry sequence; no access meanwhile
    pchk(1'b1);
    st.uart_mode = 1'b0;
    $display("test pullup done");
  endtask : t_pullup
  task t_events;
    lm.wr(ppc_pkg::ADDR_WRITE, 8'h04);
    ev(1'b1, 1);
    ev(1'b0, 0);
    lm.wr(ppc_pkg::ADDR_WRITE, 8'h08);
    ev(1'b1, 0);
    ev(1'b0, 1);
    $display("test events done");
  endtask : t_events
  // Mid-run reset must drop every enable set before it
  task t_reset;
    lm.wr(ppc_pkg::ADDR_WRITE, 8'h1C);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk("pullup_reset", 8'h00, {7'h00, pu});
    rreg(ppc_pkg::ADDR_WRITE, 8'h00);
    ev(1'b1, 0);
    ev(1'b0, 0);
    $display("test reset done");
  endtask : t_reset
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 0;
    t_regs();
    t_pullup();
    t_events();
    t_reset();
    end_sim();
  end
  // Tests need about a hundred cycles; this limit of 5000 cycles is far beyond
  initial begin
    #20000;
    errors++;
    end_sim();
  end
endmodule : tb_top
